/* File: core/mie_alu.sv */
// Arithmetic and logic unit with flag generation
`timescale 1ns/1ps
module mie_alu (
  input wire mie_pkg::mie_op_t opc_in,
  input wire logic [7:0] work_in,
  input wire logic [7:0] opnd_in,
  input wire logic carry_in,
  input wire logic nib_carry_in,
  input wire logic [2:0] bit_sel_in,
  output logic [7:0] res_out,
  output logic carry_out,
  output logic nib_carry_out,
  output logic zero_out,
  output logic wr_zero_out,
  output logic wr_nib_out,
  output logic wr_carry_out
);
  logic is_sub;
  logic [7:0] ax;
  logic ci;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic [8:0] adj_lo;
  logic adj_hi;

  // Subtract forms add the one's complement; only CMP adds an implicit +1
  assign is_sub = opc_in inside {mie_pkg::OP_SUB_R, mie_pkg::OP_SBC_R, mie_pkg::OP_SUB_I, mie_pkg::OP_SBC_I,
                                 mie_pkg::OP_CMP};
  assign ax = is_sub ? ~work_in : work_in;
  assign ci = (opc_in inside {mie_pkg::OP_ADC_R, mie_pkg::OP_SBC_R, mie_pkg::OP_ADC_I, mie_pkg::OP_SBC_I})
              ? carry_in : (opc_in == mie_pkg::OP_CMP);
  assign sum = {1'b0, opnd_in} + {1'b0, ax} + {8'h00, ci};
  assign hsum = {1'b0, opnd_in[3:0]} + {1'b0, ax[3:0]} + {4'h0, ci};
  assign adj_lo = {1'b0, work_in} + ((work_in[3:0] > mie_pkg::MIE_BCD_MAX || nib_carry_in) ? mie_pkg::MIE_BCD_LO
                                                                                           : 9'h000);
  assign adj_hi = adj_lo[8] || adj_lo[7:4] > mie_pkg::MIE_BCD_MAX || carry_in;
  assign zero_out = (res_out == 8'h00);

  always_comb begin
    res_out = opnd_in;
    carry_out = carry_in;
    nib_carry_out = nib_carry_in;
    wr_zero_out = 1'b0;
    wr_nib_out = 1'b0;
    wr_carry_out = 1'b0;
    case (opc_in)
      mie_pkg::OP_ADD_R, mie_pkg::OP_SUB_R, mie_pkg::OP_ADC_R, mie_pkg::OP_SBC_R,
      mie_pkg::OP_ADD_I, mie_pkg::OP_SUB_I, mie_pkg::OP_ADC_I, mie_pkg::OP_SBC_I: begin
        res_out = sum[7:0];
        carry_out = sum[8];
        nib_carry_out = hsum[4];
        wr_zero_out = 1'b1;
        wr_nib_out = 1'b1;
        wr_carry_out = 1'b1;
      end
      mie_pkg::OP_CMP: begin
        res_out = sum[7:0];
        carry_out = sum[8];
        wr_zero_out = 1'b1;
        wr_carry_out = 1'b1;
      end
      mie_pkg::OP_AND_R, mie_pkg::OP_AND_I: begin
        res_out = work_in & opnd_in;
        wr_zero_out = 1'b1;
      end
      mie_pkg::OP_OR_R, mie_pkg::OP_OR_I: begin
        res_out = work_in | opnd_in;
        wr_zero_out = 1'b1;
      end
      mie_pkg::OP_XOR_R, mie_pkg::OP_XOR_I: begin
        res_out = work_in ^ opnd_in;
        wr_zero_out = 1'b1;
      end
      mie_pkg::OP_COM: begin
        res_out = ~opnd_in;
        wr_zero_out = 1'b1;
      end
      mie_pkg::OP_MOVR: wr_zero_out = 1'b1;
      mie_pkg::OP_CLRW, mie_pkg::OP_CLRR: begin
        res_out = 8'h00;
        wr_zero_out = 1'b1;
      end
      mie_pkg::OP_INC, mie_pkg::OP_DEC: begin
        res_out = (opc_in == mie_pkg::OP_INC) ? opnd_in + 8'h01 : opnd_in - 8'h01;
        wr_zero_out = 1'b1;
      end
      mie_pkg::OP_INCSZ: res_out = opnd_in + 8'h01;
      mie_pkg::OP_DECSZ: res_out = opnd_in - 8'h01;
      mie_pkg::OP_ROR: begin
        res_out = {carry_in, opnd_in[7:1]};
        carry_out = opnd_in[0];
        wr_carry_out = 1'b1;
      end
      mie_pkg::OP_ROL: begin
        res_out = {opnd_in[6:0], carry_in};
        carry_out = opnd_in[7];
        wr_carry_out = 1'b1;
      end
      mie_pkg::OP_SWAP: res_out = {opnd_in[3:0], opnd_in[7:4]};
      mie_pkg::OP_BSET: res_out = opnd_in | (8'h01 << bit_sel_in);
      mie_pkg::OP_BCLR: res_out = opnd_in & ~(8'h01 << bit_sel_in);
      mie_pkg::OP_MOVW2R: res_out = work_in;
      mie_pkg::OP_DECADJ: begin
        res_out = adj_hi ? adj_lo[7:0] + mie_pkg::MIE_BCD_HI : adj_lo[7:0];
        carry_out = adj_hi;
        wr_carry_out = 1'b1;
      end
      default: ;
    endcase
  end
endmodule : mie_alu

/* File: core/mie_core.sv */
// Instruction decode and execute core with program counter, stack and flags
`timescale 1ns/1ps
module mie_core #(
  parameter int PCW = 10,
  parameter int SDEP = 8
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  output logic [PCW-1:0] pc_out,
  input wire logic [15:0] instr_in,
  output logic [6:0] r_raddr_out,
  input wire logic [7:0] r_rdata_in,
  output logic [6:0] r_waddr_out,
  output logic [7:0] r_wdata_out,
  output logic r_we_out,
  output logic [3:0] f_addr_out,
  input wire logic [7:0] f_rdata_in,
  output logic [7:0] f_wdata_out,
  output logic f_we_out,
  output logic [4:0] s_addr_out,
  input wire logic [7:0] s_rdata_in,
  output logic [7:0] s_wdata_out,
  output logic s_we_out,
  input wire logic wdt_timeout_in,
  output logic sleep_out,
  output logic wdt_clear_out,
  output logic [7:0] work_out,
  output logic carry_out,
  output logic nibble_carry_out,
  output logic zero_out,
  output logic timeout_flag_out,
  output logic power_down_flag_out,
  output logic gie_out,
  output logic [7:0] t0md_out,
  output logic [7:0] table_high_data_out
);
  localparam int SPW = $clog2(SDEP);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [PCW-1:0] pc_q, pc_d, pc_inc, ind_tgt, tbl_addr_q;
  logic [PCW-1:0] stk_q [SDEP];
  logic [SPW-1:0] sp_q, sp_top;
  logic [1:0] bub_q, bub_d;
  logic adv_q, tbl_q;
  logic [7:0] work_q, t0md_q, table_high_data_q;
  logic c_q, dc_q, z_q, to_q, pd_q, gie_q;
  logic r_we_q;
  logic [6:0] r_waddr_q;
  logic [7:0] r_wdata_q;
  mie_pkg::mie_op_t opc;
  logic ex, dsel, wk, rg, skip, push, pop, hold_br;
  logic [6:0] r_idx;
  logic [2:0] bsel;
  logic [7:0] lit, r_val, opnd, alu_res;
  logic alu_c, alu_dc, alu_z, wz, wdc, wc;

  // Reset released through two flops
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Field extraction; encoding is fixed by the package
  assign opc = mie_pkg::mie_op_t'(instr_in[mie_pkg::MIE_OPC_HI:mie_pkg::MIE_OPC_LO]);
  // Gated by reset so no strobe leaks while program memory is being loaded
  assign ex = rst_n && (bub_q == 2'h0);
  assign r_idx = instr_in[mie_pkg::MIE_R_HI:0];
  assign dsel = instr_in[mie_pkg::MIE_D_BIT];
  assign bsel = instr_in[mie_pkg::MIE_BIT_HI:mie_pkg::MIE_BIT_LO];
  assign lit = instr_in[mie_pkg::MIE_LIT_HI:0];
  // Bypass covers the one-cycle lag of the registered write port
  assign r_val = (r_we_q && r_waddr_q == r_idx) ? r_wdata_q : r_rdata_in;

  always_comb begin
    wk = 1'b0;
    rg = 1'b0;
    opnd = r_val;
    case (opc)
      mie_pkg::OP_AND_R, mie_pkg::OP_OR_R, mie_pkg::OP_XOR_R, mie_pkg::OP_ROR, mie_pkg::OP_ROL,
      mie_pkg::OP_INC, mie_pkg::OP_DEC, mie_pkg::OP_COM, mie_pkg::OP_MOVR, mie_pkg::OP_SWAP,
      mie_pkg::OP_ADD_R, mie_pkg::OP_SUB_R, mie_pkg::OP_ADC_R, mie_pkg::OP_SBC_R,
      mie_pkg::OP_INCSZ, mie_pkg::OP_DECSZ: begin
        wk = !dsel;
        rg = dsel;
      end
      mie_pkg::OP_AND_I, mie_pkg::OP_OR_I, mie_pkg::OP_XOR_I, mie_pkg::OP_ADD_I, mie_pkg::OP_SUB_I,
      mie_pkg::OP_ADC_I, mie_pkg::OP_SBC_I, mie_pkg::OP_LDLIT, mie_pkg::OP_RETL: begin
        wk = 1'b1;
        opnd = lit;
      end
      mie_pkg::OP_DECADJ, mie_pkg::OP_CLRW: wk = 1'b1;
      mie_pkg::OP_FRD: begin
        wk = 1'b1;
        opnd = f_rdata_in;
      end
      mie_pkg::OP_SRD: begin
        wk = 1'b1;
        opnd = s_rdata_in;
      end
      mie_pkg::OP_TRD: begin
        wk = 1'b1;
        opnd = t0md_q;
      end
      mie_pkg::OP_MOVW2R, mie_pkg::OP_CLRR, mie_pkg::OP_BSET, mie_pkg::OP_BCLR: rg = 1'b1;
      default: ;
    endcase
  end

  mie_alu u_alu (
    .opc_in(opc),
    .work_in(work_q),
    .opnd_in(opnd),
    .carry_in(c_q),
    .nib_carry_in(dc_q),
    .bit_sel_in(bsel),
    .res_out(alu_res),
    .carry_out(alu_c),
    .nib_carry_out(alu_dc),
    .zero_out(alu_z),
    .wr_zero_out(wz),
    .wr_nib_out(wdc),
    .wr_carry_out(wc)
  );

  // Sequencing: skipped or flushed words become bubbles
  assign skip = ex && ((opc == mie_pkg::OP_SKBC && !r_val[bsel]) || (opc == mie_pkg::OP_SKBS && r_val[bsel])
                || ((opc == mie_pkg::OP_INCSZ || opc == mie_pkg::OP_DECSZ) && alu_z));
  assign hold_br = opc inside {mie_pkg::OP_ICALL, mie_pkg::OP_IJMP, mie_pkg::OP_CALL, mie_pkg::OP_JMP,
                               mie_pkg::OP_RET, mie_pkg::OP_RETI, mie_pkg::OP_RETL, mie_pkg::OP_TBL};
  assign push = ex && (opc inside {mie_pkg::OP_ICALL, mie_pkg::OP_CALL, mie_pkg::OP_SWI});
  assign pop = ex && (opc inside {mie_pkg::OP_RET, mie_pkg::OP_RETI, mie_pkg::OP_RETL});
  assign bub_d = (opc == mie_pkg::OP_SWI) ? mie_pkg::MIE_BUB_TWO
                 : (skip || hold_br) ? mie_pkg::MIE_BUB_ONE : 2'h0;
  assign pc_inc = pc_q + PCW'(1);
  assign ind_tgt = {pc_q[PCW-1:mie_pkg::MIE_DW], work_q};
  assign sp_top = sp_q - SPW'(1);

  always_comb begin
    pc_d = pc_inc;
    if (!ex) begin
      pc_d = adv_q ? pc_inc : pc_q;
    end else begin
      case (opc)
        mie_pkg::OP_ICALL, mie_pkg::OP_IJMP: pc_d = ind_tgt;
        mie_pkg::OP_CALL, mie_pkg::OP_JMP: pc_d = PCW'(instr_in[mie_pkg::MIE_ADR_HI:0]);
        mie_pkg::OP_SWI: pc_d = PCW'(mie_pkg::MIE_INT_VEC);
        mie_pkg::OP_RET, mie_pkg::OP_RETI, mie_pkg::OP_RETL: pc_d = stk_q[sp_top];
        default: pc_d = pc_inc;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= '0;
      bub_q <= 2'h0;
      adv_q <= 1'b0;
      tbl_q <= 1'b0;
      tbl_addr_q <= '0;
      sp_q <= '0;
    end else begin
      pc_q <= pc_d;
      bub_q <= ex ? bub_d : bub_q - 2'h1;
      adv_q <= ex ? skip : adv_q;
      tbl_q <= ex && opc == mie_pkg::OP_TBL;
      tbl_addr_q <= ind_tgt;
      sp_q <= push ? sp_q + SPW'(1) : pop ? sp_top : sp_q;
    end
  end

  // Stack is data only; overflow wraps silently
  always_ff @(posedge sys_clk_in) begin
    if (push)
      stk_q[sp_q] <= pc_inc;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      work_q <= mie_pkg::MIE_WORK_RST;
      c_q <= mie_pkg::MIE_FLAG_RST;
      dc_q <= mie_pkg::MIE_FLAG_RST;
      z_q <= mie_pkg::MIE_FLAG_RST;
      r_we_q <= 1'b0;
      r_waddr_q <= '0;
      r_wdata_q <= '0;
    end else begin
      if (ex && wk)
        work_q <= alu_res;
      if (ex && wc)
        c_q <= alu_c;
      if (ex && wdc)
        dc_q <= alu_dc;
      if (ex && wz)
        z_q <= alu_z;
      r_we_q <= ex && rg;
      r_waddr_q <= r_idx;
      r_wdata_q <= alu_res;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      to_q <= mie_pkg::MIE_TO_RST;
      pd_q <= mie_pkg::MIE_PD_RST;
      gie_q <= 1'b0;
      t0md_q <= '0;
      table_high_data_q <= '0;
    end else begin
      // A timeout event beats a same-cycle sleep or clear
      if (wdt_timeout_in)
        to_q <= 1'b0;
      else if (ex && (opc == mie_pkg::OP_SLEEP || opc == mie_pkg::OP_WDCLR))
        to_q <= 1'b1;
      if (ex && opc == mie_pkg::OP_SLEEP)
        pd_q <= 1'b0;
      else if (ex && opc == mie_pkg::OP_WDCLR)
        pd_q <= 1'b1;
      if (ex && (opc == mie_pkg::OP_IEN || opc == mie_pkg::OP_RETI))
        gie_q <= 1'b1;
      else if (ex && (opc == mie_pkg::OP_IDIS || opc == mie_pkg::OP_SWI))
        gie_q <= 1'b0;
      if (ex && opc == mie_pkg::OP_TWR)
        t0md_q <= work_q;
      if (tbl_q)
        table_high_data_q <= instr_in[mie_pkg::MIE_IW-1:mie_pkg::MIE_DW];
    end
  end

  assign pc_out = tbl_q ? tbl_addr_q : pc_q;
  assign r_raddr_out = r_idx;
  assign r_waddr_out = r_waddr_q;
  assign r_wdata_out = r_wdata_q;
  assign r_we_out = r_we_q;
  assign f_addr_out = instr_in[mie_pkg::MIE_F_HI:0];
  assign f_wdata_out = work_q;
  assign f_we_out = ex && opc == mie_pkg::OP_FWR && f_addr_out >= mie_pkg::MIE_F_MIN;
  assign s_addr_out = instr_in[mie_pkg::MIE_S_HI:0];
  assign s_wdata_out = work_q;
  assign s_we_out = ex && opc == mie_pkg::OP_SWR;
  assign sleep_out = ex && opc == mie_pkg::OP_SLEEP;
  assign wdt_clear_out = ex && opc == mie_pkg::OP_WDCLR;
  assign work_out = work_q;
  assign carry_out = c_q;
  assign nibble_carry_out = dc_q;
  assign zero_out = z_q;
  assign timeout_flag_out = to_q;
  assign power_down_flag_out = pd_q;
  assign gie_out = gie_q;
  assign t0md_out = t0md_q;
  assign table_high_data_out = table_high_data_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  dest_work_a: assert property (ex && opc == mie_pkg::OP_ADD_R && !dsel |=>
    work_q == $past(work_q) + $past(r_val) && !r_we_out) else $error("add to work wrong");
  dest_reg_a: assert property (ex && opc == mie_pkg::OP_ADD_R && dsel |=>
    r_we_out && r_waddr_out == $past(r_idx) && $stable(work_q)) else $error("add to reg wrong");
  bit_set_a: assert property (ex && opc == mie_pkg::OP_BSET |=>
    r_wdata_out[$past(bsel)] && $stable(c_q) && $stable(z_q) && $stable(dc_q)) else $error("bit set wrong");
  skip_two_a: assert property (skip && !tbl_q |-> ##2 pc_q == $past(pc_q, 2) + PCW'(2))
    else $error("skip length wrong");
  ijmp_hold_a: assert property (ex && opc == mie_pkg::OP_IJMP |=>
    pc_q == $past(ind_tgt) && !ex ##1 ex && pc_q == $past(pc_q)) else $error("indirect jump wrong");
  lit_flags_a: assert property (ex && opc == mie_pkg::OP_LDLIT |=>
    work_q == $past(lit) && $stable(z_q) && $stable(c_q)) else $error("load literal wrong");
  sleep_flags_a: assert property (ex && opc == mie_pkg::OP_SLEEP && !wdt_timeout_in |=>
    to_q && !pd_q) else $error("sleep flags wrong");
  wdclr_flags_a: assert property (ex && opc == mie_pkg::OP_WDCLR && !wdt_timeout_in |=>
    to_q && pd_q) else $error("clear flags wrong");
  fpage_rd_a: assert property (ex && opc == mie_pkg::OP_FRD |=> work_q == $past(f_rdata_in) && $stable(z_q))
    else $error("f-page read wrong");
  reti_gie_a: assert property (ex && opc == mie_pkg::OP_RETI |=> gie_q && !ex ##1 ex)
    else $error("interrupt return wrong");
endmodule : mie_core

/* File: core/mie_pkg.sv */
// Shared constants and opcode map for the instruction execution core
package mie_pkg;
  localparam int MIE_DW = 8;
  localparam int MIE_IW = 16;
  localparam int MIE_OPC_HI = 15;
  localparam int MIE_OPC_LO = 10;
  localparam int MIE_R_HI = 6;
  localparam int MIE_D_BIT = 7;
  localparam int MIE_BIT_HI = 9;
  localparam int MIE_BIT_LO = 7;
  localparam int MIE_LIT_HI = 7;
  localparam int MIE_ADR_HI = 9;
  localparam int MIE_F_HI = 3;
  localparam int MIE_S_HI = 4;
  localparam logic [3:0] MIE_F_MIN = 4'h5;
  localparam logic [9:0] MIE_INT_VEC = 10'h008;
  localparam logic [7:0] MIE_WORK_RST = 8'h00;
  localparam logic MIE_FLAG_RST = 1'b0;
  localparam logic MIE_TO_RST = 1'b1;
  localparam logic MIE_PD_RST = 1'b1;
  localparam logic [1:0] MIE_BUB_ONE = 2'h1;
  localparam logic [1:0] MIE_BUB_TWO = 2'h2;
  localparam logic [3:0] MIE_BCD_MAX = 4'h9;
  localparam logic [8:0] MIE_BCD_LO = 9'h006;
  localparam logic [7:0] MIE_BCD_HI = 8'h60;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_AND_R = 6'h01, OP_OR_R = 6'h02, OP_XOR_R = 6'h03,
    OP_AND_I = 6'h04, OP_OR_I = 6'h05, OP_XOR_I = 6'h06, OP_ROR = 6'h07,
    OP_ROL = 6'h08, OP_BSET = 6'h09, OP_BCLR = 6'h0a, OP_INC = 6'h0b,
    OP_DEC = 6'h0c, OP_COM = 6'h0d, OP_SKBC = 6'h0e, OP_SKBS = 6'h0f,
    OP_INCSZ = 6'h10, OP_DECSZ = 6'h11, OP_MOVW2R = 6'h12, OP_MOVR = 6'h13,
    OP_LDLIT = 6'h14, OP_SWAP = 6'h15, OP_FWR = 6'h16, OP_FRD = 6'h17,
    OP_SWR = 6'h18, OP_SRD = 6'h19, OP_TWR = 6'h1a, OP_TRD = 6'h1b,
    OP_TBL = 6'h1c, OP_ADD_R = 6'h1d, OP_SUB_R = 6'h1e, OP_ADC_R = 6'h1f,
    OP_SBC_R = 6'h20, OP_ADD_I = 6'h21, OP_SUB_I = 6'h22, OP_ADC_I = 6'h23,
    OP_SBC_I = 6'h24, OP_DECADJ = 6'h25, OP_CMP = 6'h26, OP_CLRW = 6'h27,
    OP_CLRR = 6'h28, OP_SLEEP = 6'h29, OP_WDCLR = 6'h2a, OP_IEN = 6'h2b,
    OP_IDIS = 6'h2c, OP_SWI = 6'h2d, OP_RET = 6'h2e, OP_RETI = 6'h2f,
    OP_RETL = 6'h30, OP_ICALL = 6'h31, OP_IJMP = 6'h32, OP_CALL = 6'h33,
    OP_JMP = 6'h34
  } mie_op_t;
endpackage : mie_pkg

/* File: verif/mcu_instruction_execution_tb.sv */
// Self-checking bench for the instruction execution core
`timescale 1ns/1ps
module mcu_instruction_execution_tb;
  logic sys_clk, arst_n, ld_we, wdt, r_we, f_we, s_we, c_f, dc_f, z_f, to_f, pd_f, gie, slp, wclr;
  logic [9:0] ld_addr, pc;
  logic [15:0] ld_data, instr;
  logic [6:0] r_ra, r_wa, peek;
  logic [7:0] r_rd, r_wd, f_rd, f_wd, s_rd, s_wd, work, thd, pk_r, pk_f, pk_s, t0md;
  logic [3:0] f_a;
  logic [4:0] s_a;
  logic [9:0] pa[$];
  logic [15:0] pw[$];
  logic [31:0] seed = 32'h000067bc;
  int errors = 0;
  int num_checks = 0;
  int n_slp, n_wdc;
  // Index tells the class: 0-6 literal, 21-22 bit ops
  mie_pkg::mie_op_t ops [26] = '{mie_pkg::OP_ADD_I, mie_pkg::OP_SUB_I, mie_pkg::OP_ADC_I,
    mie_pkg::OP_SBC_I, mie_pkg::OP_AND_I, mie_pkg::OP_OR_I, mie_pkg::OP_XOR_I, mie_pkg::OP_ADD_R,
    mie_pkg::OP_SUB_R, mie_pkg::OP_ADC_R, mie_pkg::OP_SBC_R, mie_pkg::OP_AND_R, mie_pkg::OP_OR_R,
    mie_pkg::OP_XOR_R, mie_pkg::OP_COM, mie_pkg::OP_MOVR, mie_pkg::OP_INC, mie_pkg::OP_DEC,
    mie_pkg::OP_SWAP, mie_pkg::OP_ROR, mie_pkg::OP_ROL, mie_pkg::OP_BSET, mie_pkg::OP_BCLR,
    mie_pkg::OP_CLRR, mie_pkg::OP_CLRW, mie_pkg::OP_CMP};
  mie_pkg::mie_op_t sk [4] = '{mie_pkg::OP_SKBS, mie_pkg::OP_SKBC, mie_pkg::OP_INCSZ, mie_pkg::OP_DECSZ};

  mie_core dut_u (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .pc_out(pc), .instr_in(instr),
    .r_raddr_out(r_ra), .r_rdata_in(r_rd), .r_waddr_out(r_wa), .r_wdata_out(r_wd), .r_we_out(r_we),
    .f_addr_out(f_a), .f_rdata_in(f_rd), .f_wdata_out(f_wd), .f_we_out(f_we),
    .s_addr_out(s_a), .s_rdata_in(s_rd), .s_wdata_out(s_wd), .s_we_out(s_we),
    .wdt_timeout_in(wdt), .sleep_out(slp), .wdt_clear_out(wclr), .work_out(work), .carry_out(c_f),
    .nibble_carry_out(dc_f), .zero_out(z_f), .timeout_flag_out(to_f), .power_down_flag_out(pd_f),
    .gie_out(gie), .t0md_out(t0md), .table_high_data_out(thd));
  mie_far_model far_u (.clk_in(sys_clk), .ld_we_in(ld_we), .ld_addr_in(ld_addr), .ld_data_in(ld_data),
    .pc_in(pc), .instr_out(instr), .r_raddr_in(r_ra), .r_rdata_out(r_rd), .r_waddr_in(r_wa),
    .r_wdata_in(r_wd), .r_we_in(r_we), .f_addr_in(f_a), .f_rdata_out(f_rd), .f_wdata_in(f_wd),
    .f_we_in(f_we), .s_addr_in(s_a), .s_rdata_out(s_rd), .s_wdata_in(s_wd), .s_we_in(s_we),
    .peek_in(peek), .peek_r_out(pk_r), .peek_f_out(pk_f), .peek_s_out(pk_s));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] bcd(int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  // Returns {work, reg, C, DC, Z}; all three flags start equal to c
  function automatic logic [18:0] calc(int i, logic [7:0] a, logic [7:0] b, logic c, logic d, logic [2:0] k);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] res, w, r;
    logic cc, dd, zz, sub, cin;
    sub = (i == 1 || i == 3 || i == 8 || i == 10);
    cin = c & (i == 2 || i == 3 || i == 9 || i == 10);
    s = {1'b0, b} + {1'b0, sub ? ~a : a} + {8'h00, cin};
    n = {1'b0, b[3:0]} + {1'b0, sub ? ~a[3:0] : a[3:0]} + {4'h0, cin};
    w = a;
    r = b;
    cc = c;
    dd = c;
    zz = c;
    res = s[7:0];
    case (i)
      4, 11: res = a & b;
      5, 12: res = a | b;
      6, 13: res = a ^ b;
      14: res = ~b;
      15: res = b;
      16: res = b + 8'h01;
      17: res = b - 8'h01;
      18: res = {b[3:0], b[7:4]};
      19: {res, cc} = {c, b};
      20: {cc, res} = {b, c};
      21: res = b | (8'h01 << k);
      22: res = b & ~(8'h01 << k);
      23, 24: res = 8'h00;
      25: {cc, res} = {1'b0, b} + {1'b0, ~a} + 9'h001;
      default: res = s[7:0];
    endcase
    if (i < 4 || (i > 6 && i < 11)) {cc, dd} = {s[8], n[4]};
    if (i < 18 || i > 22) zz = (res == 8'h00);
    if (i < 7 || i == 24 || (i < 21 && !d)) w = res;
    else if (i < 25) r = res;
    return {w, r, cc, dd, zz};
  endfunction : calc

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic put(logic [9:0] a, logic [15:0] w);
    pa.push_back(a);
    pw.push_back(w);
  endtask : put

  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Program loads while the core sits in reset; watchdog pulse after address 1
  task automatic run(logic [9:0] fin);
    int n;
    bit hit;
    @(posedge sys_clk);
    arst_n <= 1'b0;
    foreach (pa[i]) begin
      ld_we <= 1'b1;
      ld_addr <= pa[i];
      ld_data <= pw[i];
      @(posedge sys_clk);
    end
    ld_we <= 1'b0;
    pa.delete();
    pw.delete();
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    n = 0;
    hit = 1'b0;
    n_slp = 0;
    n_wdc = 0;
    while (pc !== fin) begin
      @(posedge sys_clk);
      n_slp += slp;
      n_wdc += wclr;
      wdt <= (pc === 10'h001) && !hit;
      hit = hit || (pc === 10'h001);
      n++;
      if (n > 300) begin
        errors++;
        $display("MISMATCH pc expected %h seen %h", fin, pc);
        report_and_stop();
      end
    end
    wdt <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : run

  initial begin
    int i, x, y;
    logic [31:0] v;
    logic [18:0] e;
    logic [7:0] a, b, val, res;
    logic [6:0] r;
    logic [2:0] k;
    logic c, d, skip;
    arst_n = 1'b0;
    ld_we = 1'b0;
    ld_addr = 10'h000;
    ld_data = 16'h0000;
    wdt = 1'b0;
    peek = 7'h00;
    for (int j = 0; j < 60; j++) begin
      v = rnd();
      {r, k, d, c, b, a} = v[27:0];
      i = (j < 26) ? j : int'(rnd() % 32'd26);
      if (j[2]) b = a;
      if (j[3]) a = 8'hff;
      e = calc(i, a, b, c, d, k);
      put(10'h000, {mie_pkg::OP_LDLIT, 2'h0, 7'h00, c});
      put(10'h001, {mie_pkg::OP_ADD_I, 2'h0, 8'hff});
      put(10'h002, {mie_pkg::OP_LDLIT, 2'h0, b});
      put(10'h003, {mie_pkg::OP_MOVW2R, 3'h0, r});
      put(10'h004, {mie_pkg::OP_LDLIT, 2'h0, a});
      if (i < 7) put(10'h005, {ops[i], 2'h0, b});
      else if (i == 21 || i == 22) put(10'h005, {ops[i], k, r});
      else put(10'h005, {ops[i], 2'h0, d, r});
      put(10'h006, {mie_pkg::OP_JMP, 10'h006});
      run(10'h006);
      peek = r;
      #1;
      chk("work", e[18:11], work);
      chk("reg", e[10:3], pk_r);
      chk("flags", {5'h00, e[2:0]}, {5'h00, c_f, dc_f, z_f});
    end
    for (int j = 0; j < 8; j++) begin
      v = rnd();
      x = (j == 0) ? 99 : int'(v[7:0]) % 100;
      y = (j == 0) ? 1 : int'(v[15:8]) % 100;
      e = calc(0, bcd(x), bcd(y), 1'b0, 1'b0, 3'h0);
      put(10'h000, {mie_pkg::OP_LDLIT, 2'h0, bcd(x)});
      put(10'h001, {mie_pkg::OP_ADD_I, 2'h0, bcd(y)});
      put(10'h002, {mie_pkg::OP_DECADJ, 10'h000});
      put(10'h003, {mie_pkg::OP_JMP, 10'h003});
      run(10'h003);
      chk("bcd", bcd((x + y) % 100), work);
      chk("bcd_flags", {5'h00, (x + y > 99), e[1:0]}, {5'h00, c_f, dc_f, z_f});
    end
    for (int j = 0; j < 16; j++) begin
      v = rnd();
      val = v[7:0];
      k = v[10:8];
      d = v[11];
      if (j[3]) val = (j % 4 == 2) ? 8'hff : 8'h01;
      res = (j % 4 == 2) ? val + 8'h01 : val - 8'h01;
      skip = (j % 4 == 0) ? val[k] : (j % 4 == 1) ? !val[k] : (res == 8'h00);
      put(10'h000, {mie_pkg::OP_LDLIT, 2'h0, val});
      put(10'h001, {mie_pkg::OP_MOVW2R, 3'h0, 7'h7f});
      put(10'h002, (j % 4 < 2) ? {sk[j % 4], k, 7'h7f} : {sk[j % 4], 2'h0, d, 7'h7f});
      put(10'h003, {mie_pkg::OP_LDLIT, 2'h0, 8'h11});
      put(10'h004, {mie_pkg::OP_JMP, 10'h004});
      run(10'h004);
      peek = 7'h7f;
      #1;
      chk("skip_work", skip ? ((j % 4 > 1 && !d) ? res : val) : 8'h11, work);
      chk("skip_reg", (j % 4 > 1 && d) ? res : val, pk_r);
      chk("skip_flags", 8'h00, {5'h00, c_f, dc_f, z_f});
    end
    put(10'h000, {mie_pkg::OP_LDLIT, 2'h0, 8'h20});
    put(10'h001, {mie_pkg::OP_ICALL, 10'h000});
    put(10'h002, {mie_pkg::OP_FWR, 6'h00, 4'h7});
    put(10'h003, {mie_pkg::OP_FWR, 6'h00, 4'h4});
    put(10'h004, {mie_pkg::OP_SWR, 5'h00, 5'h1f});
    put(10'h005, {mie_pkg::OP_LDLIT, 2'h0, 8'h00});
    put(10'h006, {mie_pkg::OP_FRD, 6'h00, 4'h7});
    put(10'h007, {mie_pkg::OP_SWR, 5'h00, 5'h1e});
    put(10'h008, {mie_pkg::OP_LDLIT, 2'h0, 8'h30});
    put(10'h009, {mie_pkg::OP_TBL, 10'h000});
    put(10'h00a, {mie_pkg::OP_LDLIT, 2'h0, 8'h28});
    put(10'h00b, {mie_pkg::OP_IJMP, 10'h000});
    put(10'h00c, {mie_pkg::OP_LDLIT, 2'h0, 8'hee});
    put(10'h020, {mie_pkg::OP_RETL, 2'h0, 8'h5a});
    put(10'h028, {mie_pkg::OP_SRD, 5'h00, 5'h1f});
    put(10'h029, {mie_pkg::OP_SLEEP, 10'h000});
    put(10'h02a, {mie_pkg::OP_JMP, 10'h02a});
    put(10'h030, 16'hc3a5);
    run(10'h02a);
    chk("ctl_work", 8'h5a, work);
    chk("table_high", 8'hc3, thd);
    chk("status", 8'h04, {5'h00, to_f, pd_f, gie});
    chk("pulses", 8'h10, {4'(n_slp), 4'(n_wdc)});
    peek = 7'h07;
    #1;
    chk("f7", 8'h5a, pk_f);
    peek = 7'h04;
    #1;
    chk("f4", 8'h00, pk_f);
    peek = 7'h1e;
    #1;
    chk("s1e", 8'h5a, pk_s);
    put(10'h000, {mie_pkg::OP_LDLIT, 2'h0, 8'h3c});
    put(10'h001, {mie_pkg::OP_TWR, 10'h000});
    put(10'h002, {mie_pkg::OP_CLRW, 10'h000});
    put(10'h003, {mie_pkg::OP_IEN, 10'h000});
    put(10'h004, {mie_pkg::OP_SWI, 10'h000});
    put(10'h005, {mie_pkg::OP_NOP, 10'h000});
    put(10'h006, {mie_pkg::OP_JMP, 10'h006});
    put(10'h008, {mie_pkg::OP_CALL, 10'h010});
    put(10'h009, {mie_pkg::OP_RET, 10'h000});
    put(10'h010, {mie_pkg::OP_TRD, 10'h000});
    put(10'h011, {mie_pkg::OP_RET, 10'h000});
    run(10'h006);
    chk("t0md", 8'h3c, t0md);
    chk("nest_work", 8'h3c, work);
    chk("nest_status", 8'h02, {5'h00, to_f, pd_f, gie});
    put(10'h000, {mie_pkg::OP_SLEEP, 10'h000});
    put(10'h001, {mie_pkg::OP_LDLIT, 2'h0, 8'h05});
    put(10'h002, {mie_pkg::OP_ICALL, 10'h000});
    put(10'h003, {mie_pkg::OP_WDCLR, 10'h000});
    put(10'h004, {mie_pkg::OP_JMP, 10'h004});
    put(10'h005, {mie_pkg::OP_RETI, 10'h000});
    run(10'h004);
    chk("status2", 8'h07, {5'h00, to_f, pd_f, gie});
    chk("pulses2", 8'h11, {4'(n_slp), 4'(n_wdc)});
    report_and_stop();
  end
endmodule : mcu_instruction_execution_tb

/* File: verif/mie_far_model.sv */
// Program memory and register pages on the far side of the core
`timescale 1ns/1ps
module mie_far_model (
  input wire logic clk_in,
  input wire logic ld_we_in,
  input wire logic [9:0] ld_addr_in,
  input wire logic [15:0] ld_data_in,
  input wire logic [9:0] pc_in,
  output logic [15:0] instr_out,
  input wire logic [6:0] r_raddr_in,
  output logic [7:0] r_rdata_out,
  input wire logic [6:0] r_waddr_in,
  input wire logic [7:0] r_wdata_in,
  input wire logic r_we_in,
  input wire logic [3:0] f_addr_in,
  output logic [7:0] f_rdata_out,
  input wire logic [7:0] f_wdata_in,
  input wire logic f_we_in,
  input wire logic [4:0] s_addr_in,
  output logic [7:0] s_rdata_out,
  input wire logic [7:0] s_wdata_in,
  input wire logic s_we_in,
  input wire logic [6:0] peek_in,
  output logic [7:0] peek_r_out,
  output logic [7:0] peek_f_out,
  output logic [7:0] peek_s_out
);
  logic [15:0] rom_q [1024];
  logic [7:0] r_q [128];
  logic [7:0] f_q [16];
  logic [7:0] s_q [32];
  initial begin
    foreach (rom_q[i]) rom_q[i] = 16'h0000;
    foreach (r_q[i]) r_q[i] = 8'h00;
    foreach (f_q[i]) f_q[i] = 8'h00;
    foreach (s_q[i]) s_q[i] = 8'h00;
  end
  // Combinational ROM, table reads see the same path
  assign instr_out = rom_q[pc_in];
  assign r_rdata_out = r_q[r_raddr_in];
  assign f_rdata_out = f_q[f_addr_in];
  assign s_rdata_out = s_q[s_addr_in];
  assign peek_r_out = r_q[peek_in];
  assign peek_f_out = f_q[peek_in[3:0]];
  assign peek_s_out = s_q[peek_in[4:0]];
  // Low F addresses stored too, so a stray strobe shows up
  always @(posedge clk_in) begin
    if (ld_we_in) rom_q[ld_addr_in] <= ld_data_in;
    if (r_we_in) r_q[r_waddr_in] <= r_wdata_in;
    if (f_we_in) f_q[f_addr_in] <= f_wdata_in;
    if (s_we_in) s_q[s_addr_in] <= s_wdata_in;
  end
endmodule : mie_far_model
